// ===== inc/ccs_pkg.sv
// Shared constants and types for the compare-skip and ALU execution block.
package ccs_pkg;
    // Register map, byte addresses on the AXI4-Lite bus.
    localparam logic [7:0] ADDR_ACC   = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_CMD   = 8'h08;
    localparam logic [7:0] ADDR_INFO  = 8'h0C;
    localparam logic [7:0] ADDR_WDOG  = 8'h10;
    localparam logic [7:0] ADDR_MEM   = 8'h40;
    localparam int         MEM_DEPTH  = 16;
    localparam int         WDOG_W     = 8;
    localparam int         PS_W       = 4;
    // Flag bit positions and their value after reset.
    localparam int         FLG_C      = 0;
    localparam int         FLG_HALF   = 1;
    localparam int         FLG_Z      = 2;
    localparam int         FLG_OV     = 3;
    localparam int         FLG_N      = 4;
    localparam int         FLG_EXP    = 5;
    localparam int         FLG_SLP    = 6;
    localparam logic [6:0] FLAGS_RST  = 7'h60;
    localparam logic [6:0] FLAGS_SW   = 7'h1F;
    // Command word fields.
    localparam int         CMD_OP     = 0;
    localparam int         CMD_DEST   = 3;
    localparam int         CMD_ADDR   = 4;
    localparam int         CMD_TWO    = 8;
    // Decimal adjust constants.
    localparam logic [3:0] BCD_MAX    = 4'h9;
    localparam logic [8:0] BCD_FIX_LO = 9'h006;
    localparam logic [8:0] BCD_FIX_HI = 9'h060;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_ERR   = 2'h2;

    typedef enum logic [2:0] {
        OP_CSEQ = 3'h0,
        OP_CSGT = 3'h1,
        OP_CSLT = 3'h2,
        OP_INV  = 3'h3,
        OP_ZERO = 3'h4,
        OP_DADJ = 3'h5,
        OP_KICK = 3'h6,
        OP_NOP  = 3'h7
    } ccs_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_EXEC  = 2'h1,
        ST_SKIP1 = 2'h3,
        ST_SKIP2 = 2'h2
    } ccs_state_t;
endpackage

// ===== inc/ccs_alu_if.sv
// Operand and result bundle between the sequencer and the ALU.
`timescale 1ns/1ps
interface ccs_alu_if;
    import ccs_pkg::*;
    ccs_op_t    op;
    logic [7:0] fval;
    logic [7:0] acc;
    logic       c_in;
    logic       half_in;
    logic [7:0] result;
    logic       skip;
    logic       c_out;
    logic       z_out;
    logic       n_out;
    modport alu  (input op, fval, acc, c_in, half_in, output result, skip, c_out, z_out, n_out);
    modport core (output op, fval, acc, c_in, half_in, input result, skip, c_out, z_out, n_out);
endinterface

// ===== rtl/ccs_alu.sv
// Combinational datapath: compares, complement, clear and decimal adjust.
`timescale 1ns/1ps
module ccs_alu
    import ccs_pkg::*;
(
    ccs_alu_if.alu a
);
    logic [8:0] diff;
    logic [8:0] tmp;

    // Compares are done by a 9-bit subtraction so the borrow gives the unsigned order.
    always_comb begin
        diff    = {1'b0, a.fval} - {1'b0, a.acc};
        tmp     = 9'h000;
        a.result = 8'h00;
        a.skip  = 1'b0;
        a.c_out = a.c_in;
        case (a.op)
            OP_CSEQ: a.skip = (diff == 9'h000);
            OP_CSGT: a.skip = !diff[8] && (diff != 9'h000);
            OP_CSLT: a.skip = diff[8];
            OP_INV:  a.result = ~a.fval;
            OP_ZERO: a.result = 8'h00;
            OP_DADJ: begin
                // Low nibble carry ripples into the high nibble, as a packed BCD sum needs.
                tmp = {1'b0, a.acc};
                if (tmp[3:0] > BCD_MAX || a.half_in) begin
                    tmp = tmp + BCD_FIX_LO;
                end
                if (tmp[7:4] > BCD_MAX || a.c_in || tmp[8]) begin
                    tmp = tmp + BCD_FIX_HI;
                    a.c_out = 1'b1;
                end
                a.result = tmp[7:0];
            end
            default: a.result = 8'h00;
        endcase
        a.z_out = (a.result == 8'h00);
        a.n_out = a.result[7];
    end
endmodule

// ===== rtl/ccs_core.sv
// Instruction sequencer with skip handling, watchdog and AXI4-Lite register slave.
`timescale 1ns/1ps
// What this block does
// - Compare-equal skips next instruction when equal
// - Compare-greater skips when byte strictly larger unsigned
// - Compare-less skips when byte strictly smaller unsigned
// - Skip costs one or two extra cycles
// - Invert byte to accumulator or register
// - Decimal adjust adds six per nibble
// - Watchdog kick clears counters, sets status bits
// - Zero register clears byte, sets zero flag
module ccs_core
    import ccs_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH,
    parameter int WDW   = WDOG_W,
    parameter int PSW   = PS_W
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready
);
    ccs_alu_if alu_bus ();

    ccs_state_t state, next_state;
    logic [7:0] acc, next_acc;
    logic [6:0] flags, next_flags;
    logic [7:0] mem [DEPTH];
    logic [7:0] next_mem [DEPTH];
    logic [8:0] cmd, next_cmd;
    logic [1:0] last_cycles, next_last_cycles;
    logic [WDW-1:0] wdog_count, next_wdog_count;
    logic [PSW-1:0] post, next_post;
    logic [7:0] aw_addr, next_aw_addr;
    logic [8:0] w_data, next_w_data;
    logic [1:0] w_strb, next_w_strb;
    logic       next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic       do_write;
    logic [$clog2(DEPTH)-1:0] fidx;

    // Tell whether a bus address is a word-aligned entry inside the data memory array.
    function automatic logic mem_hit(input logic [7:0] addr);
        return addr >= ADDR_MEM && addr < ADDR_MEM + 8'(DEPTH * 4) && addr[1:0] == 2'h0;
    endfunction

    assign fidx          = cmd[CMD_ADDR +: $clog2(DEPTH)];
    assign alu_bus.op    = ccs_op_t'(cmd[CMD_OP +: 3]);
    assign alu_bus.fval  = mem[fidx];
    assign alu_bus.acc   = acc;
    assign alu_bus.c_in  = flags[FLG_C];
    assign alu_bus.half_in = flags[FLG_HALF];

    ccs_alu u_alu (
        .a (alu_bus)
    );

    // A bus write waits while an instruction is in flight, so skipped cycles stay quiet.
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid && state == ST_IDLE;

    // Sequencer, watchdog and register writes.
    always_comb begin
        next_state       = state;
        next_acc         = acc;
        next_flags       = flags;
        next_mem         = mem;
        next_cmd         = cmd;
        next_last_cycles = last_cycles;
        next_post        = post + 1'b1;
        next_wdog_count  = (post == '1) ? wdog_count + 1'b1 : wdog_count;
        if (post == '1 && wdog_count == '1) begin
            next_flags[FLG_EXP] = 1'b0;
        end
        case (state)
            ST_IDLE: begin
                if (do_write && w_strb[0]) begin
                    if (aw_addr == ADDR_ACC) begin
                        next_acc = w_data[7:0];
                    end else if (aw_addr == ADDR_FLAGS) begin
                        // Built on next_flags so an expiry in this cycle is not lost.
                        next_flags = (next_flags & ~FLAGS_SW) | (w_data[6:0] & FLAGS_SW);
                    end else if (aw_addr == ADDR_CMD) begin
                        next_cmd   = {w_strb[1] & w_data[CMD_TWO], w_data[7:0]};
                        next_state = ST_EXEC;
                    end else if (mem_hit(aw_addr)) begin
                        next_mem[aw_addr[2 +: $clog2(DEPTH)]] = w_data[7:0];
                    end
                end
            end
            ST_EXEC: begin
                next_last_cycles = 2'h1;
                next_state = alu_bus.skip ? ST_SKIP1 : ST_IDLE;
                case (alu_bus.op)
                    OP_INV: begin
                        if (cmd[CMD_DEST]) begin
                            next_mem[fidx] = alu_bus.result;
                        end else begin
                            next_acc = alu_bus.result;
                        end
                        next_flags[FLG_Z] = alu_bus.z_out;
                        next_flags[FLG_N] = alu_bus.n_out;
                    end
                    OP_ZERO: begin
                        next_mem[fidx]    = alu_bus.result;
                        next_flags[FLG_Z] = 1'b1;
                    end
                    OP_DADJ: begin
                        next_acc          = alu_bus.result;
                        next_flags[FLG_C] = alu_bus.c_out;
                    end
                    OP_KICK: begin
                        next_wdog_count     = '0;
                        next_post           = '0;
                        next_flags[FLG_EXP] = 1'b1;
                        next_flags[FLG_SLP] = 1'b1;
                    end
                    default: next_acc = acc;
                endcase
            end
            ST_SKIP1: begin
                // Discarded word: only the cycle count, the state and the free-running watchdog move.
                next_last_cycles = 2'h2;
                next_state = cmd[CMD_TWO] ? ST_SKIP2 : ST_IDLE;
            end
            ST_SKIP2: begin
                next_last_cycles = 2'h3;
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // AXI4-Lite handshakes; the read answer is registered one cycle after the address.
    always_comb begin
        next_awready = s_axi_awready;
        next_wready  = s_axi_wready;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_arready = s_axi_arready;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awready = 1'b0;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wready = 1'b0;
            next_w_data = s_axi_wdata[8:0];
            next_w_strb = s_axi_wstrb[1:0];
        end
        if (do_write) begin
            next_bvalid = 1'b1;
            next_bresp  = (aw_addr <= ADDR_WDOG || mem_hit(aw_addr)) ? RESP_OKAY : RESP_ERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid  = 1'b0;
            next_awready = 1'b1;
            next_wready  = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = RESP_OKAY;
            if (s_axi_araddr == ADDR_ACC) begin
                next_rdata = {24'h000000, acc};
            end else if (s_axi_araddr == ADDR_FLAGS) begin
                next_rdata = {25'h0, flags};
            end else if (s_axi_araddr == ADDR_CMD) begin
                next_rdata = {23'h0, cmd};
            end else if (s_axi_araddr == ADDR_INFO) begin
                next_rdata = {28'h0000000, last_cycles, state};
            end else if (s_axi_araddr == ADDR_WDOG) begin
                next_rdata = 32'(wdog_count);
            end else if (mem_hit(s_axi_araddr)) begin
                next_rdata = {24'h000000, mem[s_axi_araddr[2 +: $clog2(DEPTH)]]};
            end else begin
                next_rdata = 32'h00000000;
                next_rresp = RESP_ERR;
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
    end

    // Register stage for all state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state         <= ST_IDLE;
            acc           <= 8'h00;
            flags         <= FLAGS_RST;
            cmd           <= 9'h000;
            last_cycles   <= 2'h0;
            wdog_count    <= '0;
            post          <= '0;
            aw_addr       <= 8'h00;
            w_data        <= 9'h000;
            w_strb        <= 2'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= 8'h00;
            end
        end else begin
            state         <= next_state;
            acc           <= next_acc;
            flags         <= next_flags;
            cmd           <= next_cmd;
            last_cycles   <= next_last_cycles;
            wdog_count    <= next_wdog_count;
            post          <= next_post;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
            mem           <= next_mem;
        end
    end

    // Checks on the execution sequence.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    skip_equal_a: assert property (state == ST_EXEC && alu_bus.op == OP_CSEQ
        |=> (state == ST_SKIP1) == ($past(alu_bus.fval) == $past(acc)))
        else $error("equal compare skip decision wrong");
    skip_greater_a: assert property (state == ST_EXEC && alu_bus.op == OP_CSGT
        |=> (state == ST_SKIP1) == ($past(alu_bus.fval) > $past(acc)))
        else $error("greater compare skip decision wrong");
    skip_less_a: assert property (state == ST_EXEC && alu_bus.op == OP_CSLT
        |=> (state == ST_SKIP1) == ($past(alu_bus.fval) < $past(acc)))
        else $error("less compare skip decision wrong");
    skip_length_a: assert property (state == ST_EXEC && alu_bus.skip
        |=> if (cmd[CMD_TWO]) (state == ST_SKIP1 ##1 state == ST_SKIP2 ##1 state == ST_IDLE)
            else (state == ST_SKIP1 ##1 state == ST_IDLE))
        else $error("skip cycle count wrong");
    invert_acc_a: assert property (state == ST_EXEC && alu_bus.op == OP_INV
        && !cmd[CMD_DEST] |=> acc == ~$past(alu_bus.fval) && flags[FLG_Z] == (acc == 8'h00))
        else $error("complement to accumulator wrong");
    bcd_carry_a: assert property (state == ST_EXEC && alu_bus.op == OP_DADJ
        && acc[7:4] > BCD_MAX |=> flags[FLG_C] && acc[7:4] <= BCD_MAX)
        else $error("decimal adjust high nibble wrong");
    kick_clear_a: assert property (state == ST_EXEC && alu_bus.op == OP_KICK
        |=> wdog_count == '0 && post == '0 && flags[FLG_EXP] && flags[FLG_SLP])
        else $error("watchdog kick incomplete");
    zero_reg_a: assert property (state == ST_EXEC && alu_bus.op == OP_ZERO
        |=> mem[$past(fidx)] == 8'h00 && flags[FLG_Z] && state == ST_IDLE
            && flags[FLG_C] == $past(flags[FLG_C]))
        else $error("zero register wrong");
    skip_quiet_a: assert property ((state == ST_SKIP1 || state == ST_SKIP2)
        |=> $stable(acc) && $stable(flags[4:0]) && $stable(cmd))
        else $error("state changed during skipped cycle");

    equal_skip_c: cover property (state == ST_EXEC && alu_bus.op == OP_CSEQ && alu_bus.skip);
    two_word_c:   cover property (state == ST_SKIP2);
    bcd_c:        cover property (state == ST_EXEC && alu_bus.op == OP_DADJ);
    kick_c:       cover property (state == ST_EXEC && alu_bus.op == OP_KICK);
endmodule

// ===== tb/ccs_axi_master.sv
// Register bus master model that drives the block's AXI4-Lite slave port.
`timescale 1ns/1ps
module ccs_axi_master (
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // The bus starts idle so the slave never sees an unknown request.
    initial begin
        s_axi_awaddr  = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
    end

    // One write; address and data go out together and each drops once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // Stale payload is inverted so a late sampler cannot see valid data.
        s_axi_wdata  <= ~d;
        s_axi_awaddr <= ~a;
    endtask

    // One read; the answer is taken at the edge where rvalid is seen high.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        s_axi_araddr <= ~a;
    endtask
endmodule

// ===== tb/cpu_compare_skip_and_alu_ops_bench.sv
// Self-checking bench for the compare-skip and ALU execution block.
`timescale 1ns/1ps
module cpu_compare_skip_and_alu_ops_bench;
    import ccs_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [3:0]  s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    int          bad_count = 0;
    int          n_tests   = 0;
    int          cycles    = 0;
    logic [7:0]  da_in  [5] = '{8'hA5, 8'hCE, 8'h99, 8'h12, 8'h00};
    logic [1:0]  da_fl  [5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h1};
    logic [7:0]  da_out [5] = '{8'h05, 8'h34, 8'h99, 8'h18, 8'h60};
    logic        da_c   [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0]  fv, wv;
    logic [1:0]  cyc;
    logic        two, skip;

    ccs_core uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ccs_axi_master m (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // Free-running 125 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // A hung handshake is cut short well past the roughly five thousand cycles needed.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            bad_count++;
            $display("Error at %0t: run timed out", $time);
            close_out();
        end
    end

    task automatic close_out();
        $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: response %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        m.wr(a, d, 4'hF, resp);
        chk_resp(resp, RESP_OKAY);
    endtask

    // Masked read, so bits moved by the free-running watchdog can be left out.
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        m.rd(a, rd_data, resp);
        chk_resp(resp, RESP_OKAY);
        chk_data(rd_data & msk, exp & msk);
    endtask

    task automatic cmd(input ccs_op_t op, input logic dest, input logic [3:0] idx,
                       input logic nxt_two);
        wr(ADDR_CMD, {23'h0, nxt_two, idx, dest, op});
    endtask

    // Main sequence of tests.
    initial begin
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(ADDR_ACC, 32'h0, 32'hFFFFFFFF);
        rchk(ADDR_FLAGS, 32'h60, 32'hFFFFFFFF);
        m.rd(8'h20, rd_data, resp);
        chk_resp(resp, RESP_ERR);
        chk_data(rd_data, 32'h0);
        m.wr(8'h24, 32'h1, 4'hF, resp);
        chk_resp(resp, RESP_ERR);
        // A write without the low byte lane must leave the register alone.
        m.wr(ADDR_ACC, 32'h55, 4'hE, resp);
        chk_resp(resp, RESP_OKAY);
        rchk(ADDR_ACC, 32'h0, 32'hFFFFFFFF);
        $display("Test reset and map done");
        // Unsigned boundary pairs: a signed compare would give the opposite answer.
        for (int op = 0; op < 3; op++) begin
            for (int k = 0; k < 3; k++) begin
                fv = (k == 1) ? 8'h7F : 8'h80;
                wv = (k == 2) ? 8'h7F : 8'h80;
                two = k[0] ^ op[0];
                skip = (op == 0) ? (fv == wv) : (op == 1) ? (fv > wv) : (fv < wv);
                cyc = skip ? (two ? 2'h3 : 2'h2) : 2'h1;
                wr(ADDR_MEM + 8'h08, {24'h0, fv});
                wr(ADDR_ACC, {24'h0, wv});
                cmd(ccs_op_t'(op), 1'b0, 4'h2, two);
                rchk(ADDR_ACC, {24'h0, wv}, 32'hFFFFFFFF);
                rchk(ADDR_MEM + 8'h08, {24'h0, fv}, 32'hFFFFFFFF);
                rchk(ADDR_INFO, {28'h0, cyc, 2'h0}, 32'hFFFFFFFF);
                rchk(ADDR_FLAGS, 32'h0, 32'h1F);
            end
        end
        $display("Test compare and skip done");
        wr(ADDR_MEM + 8'h0C, 32'h13);
        cmd(OP_INV, 1'b0, 4'h3, 1'b0);
        rchk(ADDR_ACC, 32'hEC, 32'hFFFFFFFF);
        rchk(ADDR_MEM + 8'h0C, 32'h13, 32'hFFFFFFFF);
        rchk(ADDR_FLAGS, 32'h10, 32'h1F);
        wr(ADDR_MEM + 8'h10, 32'hFF);
        cmd(OP_INV, 1'b1, 4'h4, 1'b0);
        rchk(ADDR_MEM + 8'h10, 32'h0, 32'hFFFFFFFF);
        rchk(ADDR_ACC, 32'hEC, 32'hFFFFFFFF);
        rchk(ADDR_FLAGS, 32'h04, 32'h1F);
        $display("Test invert done");
        wr(ADDR_MEM + 8'h14, 32'hAA);
        wr(ADDR_FLAGS, 32'h1B);
        cmd(OP_ZERO, 1'b0, 4'h5, 1'b0);
        rchk(ADDR_MEM + 8'h14, 32'h0, 32'hFFFFFFFF);
        rchk(ADDR_FLAGS, 32'h1F, 32'h1F);
        rchk(ADDR_INFO, 32'h4, 32'hFFFFFFFF);
        $display("Test zero register done");
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_FLAGS, {30'h0, da_fl[i]});
            wr(ADDR_ACC, {24'h0, da_in[i]});
            cmd(OP_DADJ, 1'b0, 4'h0, 1'b0);
            rchk(ADDR_ACC, {24'h0, da_out[i]}, 32'hFFFFFFFF);
            rchk(ADDR_FLAGS, {30'h0, da_fl[i][1], da_c[i]}, 32'h1F);
        end
        $display("Test decimal adjust done");
        // A no-operation leaves the data path alone; bit 8 needs its own byte lane.
        m.wr(ADDR_CMD, 32'h107, 4'h1, resp);
        chk_resp(resp, RESP_OKAY);
        rchk(ADDR_CMD, 32'h007, 32'hFFFFFFFF);
        rchk(ADDR_ACC, 32'h60, 32'hFFFFFFFF);
        rchk(ADDR_INFO, 32'h4, 32'hFFFFFFFF);
        $display("Test no-operation done");
        // Let the watchdog overflow so the kick has a cleared expiry bit to restore.
        repeat (4200) @(posedge aclk);
        rchk(ADDR_FLAGS, 32'h40, 32'h60);
        wr(ADDR_FLAGS, 32'h7F);
        rchk(ADDR_FLAGS, 32'h5F, 32'h7F);
        cmd(OP_KICK, 1'b0, 4'h0, 1'b0);
        rchk(ADDR_WDOG, 32'h0, 32'hFFFFFFFF);
        rchk(ADDR_FLAGS, 32'h60, 32'h60);
        $display("Test watchdog kick done");
        close_out();
    end
endmodule
